/* File: hdl/brk_pkg.sv */
// Package for the address breakpoint unit: register map, field layout, vectors.
// Assumes a 32-bit APB master and an 8-bit CPU core with a 16-bit address bus.
package brk_pkg;

	// ****************************************************************
	// Register offsets (byte addresses)
	// ****************************************************************
	localparam logic [7:0] OFS_CTRL_STAT  = 8'h00;
	localparam logic [7:0] OFS_ADDR_HIGH  = 8'h04;
	localparam logic [7:0] OFS_ADDR_LOW   = 8'h08;
	localparam logic [7:0] OFS_WAIT_STAT  = 8'h0c;
	localparam logic [7:0] OFS_FLAG_CLR   = 8'h10;
	localparam logic [7:0] OFS_IRQ_STAT   = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK   = 8'h18;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int         BIT_ENABLE     = 7;
	localparam int         BIT_ACTIVE     = 6;
	localparam int         BIT_WAIT_EXIT  = 1;
	localparam int         BIT_CLR_EN     = 7;
	localparam int         IRQ_BREAK      = 0;
	localparam int         IRQ_MATCH      = 1;
	localparam logic [7:0] RST_BYTE       = 8'h00;
	localparam logic [1:0] RST_IRQ        = 2'h0;

	// ****************************************************************
	// Vectors and opcodes
	// ****************************************************************
	localparam logic [15:0] VEC_NORMAL    = 16'hfffc;
	localparam logic [15:0] VEC_MONITOR   = 16'hfefc;
	localparam logic [7:0]  OPC_SWI_DFLT  = 8'h83;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PEND,
		ST_BREAK
	} brk_state_type;

	typedef struct packed {
		logic [15:0] addr;
		logic        opcode_fetch;
		logic        instr_boundary;
		logic        rti_exec;
		logic        wait_mode;
		logic        stop_mode;
	} cpu_bus_type;

	typedef struct packed {
		logic        request;
		logic        inject_swi;
		logic [7:0]  swi_opcode;
		logic [15:0] vector;
	} brk_req_type;

endpackage

/* File: hdl/brk_unit.sv */
// Address breakpoint unit: compare, software break, break state, freeze and flag controls.
// Assumes CPU bus strobes on I_CORE_CLK; test-voltage and monitor straps come from pins.
//
// Summary of operation
// - Enabled breaks request a breakpoint when program address equals break address.
// - On break inject software interrupt opcode; vector FFFC, FEFC in monitor mode.
// - Writing one to break-active bit forces a break without any address compare.
// - Match on opcode address blocks that instruction until the break routine ends.
// - Match on operand address lets the instruction finish before the break.
// - Software-forced break takes effect just before the next instruction.
// - Return-from-interrupt inside the break routine ends the break state.
// - Break enable is bit 7 of control register, read/write, cleared by reset.
// - Active bit sets on match, reset clears it; software clears by writing zero.
// - Break address held in high and low byte registers, both reset to zero.
// - Wait-exit flag reads one when a break ended wait mode, else zero.
// - During break, status clears are allowed only while clear-enable bit is one.
// - Timer counter is frozen while a break is active.
// - Watchdog is disabled during break when high test voltage is on reset pin.
// - Unit stays enabled in wait and stop; no address match can occur there.
// - Clearing active bit without a new address gives no later break on that address.
`timescale 1ns/1ps

module brk_unit #(
	parameter logic [7:0] SWI_OPCODE = brk_pkg::OPC_SWI_DFLT
) (
	// Clock and reset
	input  wire logic                 I_CORE_CLK,
	input  wire logic                 I_RESET_N,
	// APB slave
	input  wire logic                 PSEL,
	input  wire logic                 PENABLE,
	input  wire logic                 PWRITE,
	input  wire logic [7:0]           PADDR,
	input  wire logic [31:0]          PWDATA,
	input  wire logic [3:0]           PSTRB,
	output logic      [31:0]          PRDATA,
	output logic                      PREADY,
	output logic                      PSLVERR,
	// CPU core side
	input  wire brk_pkg::cpu_bus_type I_CPU,
	output brk_pkg::brk_req_type      O_BRK,
	output logic                      O_HOLD_INSTR,
	// Pins
	input  wire logic                 I_MONITOR_MODE,
	input  wire logic                 I_HIGH_TEST_VOLTAGE,
	// System controls
	output logic                      O_BREAK_ACTIVE,
	output logic                      O_STATUS_CLEAR_ALLOW,
	output logic                      O_TIMER_FREEZE,
	output logic                      O_WATCHDOG_DISABLE,
	output logic                      O_IRQ
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [1:0] mon_sync_r;
	logic [1:0] vtst_sync_r;

	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			mon_sync_r  <= 2'h0;
			vtst_sync_r <= 2'h0;
		end else begin
			mon_sync_r  <= {mon_sync_r[0], I_MONITOR_MODE};
			vtst_sync_r <= {vtst_sync_r[0], I_HIGH_TEST_VOLTAGE};
		end
	end

	// ****************************************************************
	// APB decode
	// ****************************************************************
	logic       wr_en;
	logic       rd_en;
	logic       known;
	logic [7:0] wbyte;
	logic       sel_ctrl;
	logic       sel_high;
	logic       sel_low;
	logic       sel_wait;
	logic       sel_flag;
	logic       sel_istat;
	logic       sel_imask;

	assign wbyte     = PWDATA[7:0];
	assign sel_ctrl  = (PADDR == brk_pkg::OFS_CTRL_STAT);
	assign sel_high  = (PADDR == brk_pkg::OFS_ADDR_HIGH);
	assign sel_low   = (PADDR == brk_pkg::OFS_ADDR_LOW);
	assign sel_wait  = (PADDR == brk_pkg::OFS_WAIT_STAT);
	assign sel_flag  = (PADDR == brk_pkg::OFS_FLAG_CLR);
	assign sel_istat = (PADDR == brk_pkg::OFS_IRQ_STAT);
	assign sel_imask = (PADDR == brk_pkg::OFS_IRQ_MASK);
	assign known     = sel_ctrl || sel_high || sel_low || sel_wait ||
	                   sel_flag || sel_istat || sel_imask;
	assign wr_en = PSEL && PENABLE && PWRITE && known && PSTRB[0];
	assign rd_en = PSEL && PENABLE && !PWRITE;
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !known;

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic        enable_r;
	logic        active_r;
	logic        armed_r;
	logic [7:0]  addr_high_r;
	logic [7:0]  addr_low_r;
	logic        wait_exit_r;
	logic        clr_en_r;
	logic [1:0]  irq_stat_r;
	logic [1:0]  irq_mask_r;
	logic        sw_force;
	logic        match_hit;
	logic        take_break;
	logic        rti_end;
	logic [15:0] break_addr;
	brk_pkg::brk_state_type state_r;

	assign sw_force = wr_en && (PADDR == brk_pkg::OFS_CTRL_STAT) &&
	                  wbyte[brk_pkg::BIT_ACTIVE];

	assign break_addr = {addr_high_r, addr_low_r};

	// Wait and stop modes are masked out of the compare, so they never match
	assign match_hit = enable_r && !active_r && armed_r && (I_CPU.addr == break_addr) &&
	                   !I_CPU.wait_mode && !I_CPU.stop_mode;

	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			enable_r    <= 1'b0;
			addr_high_r <= brk_pkg::RST_BYTE;
			addr_low_r  <= brk_pkg::RST_BYTE;
			clr_en_r    <= 1'b0;
			irq_mask_r  <= brk_pkg::RST_IRQ;
		end else if (wr_en) begin
			unique case (PADDR)
				brk_pkg::OFS_CTRL_STAT: begin
					enable_r <= wbyte[brk_pkg::BIT_ENABLE];
				end
				brk_pkg::OFS_ADDR_HIGH: begin
					addr_high_r <= wbyte;
				end
				brk_pkg::OFS_ADDR_LOW: begin
					addr_low_r <= wbyte;
				end
				brk_pkg::OFS_FLAG_CLR: begin
					clr_en_r <= wbyte[brk_pkg::BIT_CLR_EN];
				end
				brk_pkg::OFS_IRQ_MASK: begin
					irq_mask_r <= wbyte[1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Re-arm only on a write to either break address byte, so clearing the active bit
	// alone never lets the same address break again
	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			armed_r <= 1'b1;
		end else if (match_hit) begin
			armed_r <= 1'b0;
		end else if (wr_en && (sel_high || sel_low)) begin
			armed_r <= 1'b1;
		end
	end

	// Active bit: hardware set wins over software clear
	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			active_r <= 1'b0;
		end else if (match_hit || sw_force) begin
			active_r <= 1'b1;
		end else if (wr_en && (PADDR == brk_pkg::OFS_CTRL_STAT)) begin
			active_r <= 1'b0;
		end
	end

	// ****************************************************************
	// Break sequencing
	// ****************************************************************
	// Opcode match is taken at once with the fetch held back; operand match
	// and software break wait for the instruction boundary.
	assign take_break = (state_r == brk_pkg::ST_IDLE && match_hit && I_CPU.opcode_fetch) ||
	                    (state_r == brk_pkg::ST_PEND && I_CPU.instr_boundary);
	assign rti_end    = (state_r == brk_pkg::ST_BREAK) && I_CPU.rti_exec;

	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			state_r <= brk_pkg::ST_IDLE;
		end else begin
			unique case (state_r)
				brk_pkg::ST_IDLE: begin
					if (match_hit && I_CPU.opcode_fetch) begin
						state_r <= brk_pkg::ST_BREAK;
					end else if (match_hit || sw_force) begin
						state_r <= brk_pkg::ST_PEND;
					end
				end
				brk_pkg::ST_PEND: begin
					if (I_CPU.instr_boundary) begin
						state_r <= brk_pkg::ST_BREAK;
					end
				end
				brk_pkg::ST_BREAK: begin
					if (I_CPU.rti_exec) begin
						state_r <= brk_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// Request to the system integration logic, registered
	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_BRK <= '0;
		end else begin
			O_BRK.request    <= take_break;
			O_BRK.inject_swi <= take_break;
			O_BRK.swi_opcode <= SWI_OPCODE;
			O_BRK.vector     <= mon_sync_r[1] ? brk_pkg::VEC_MONITOR
			                                  : brk_pkg::VEC_NORMAL;
		end
	end

	assign O_HOLD_INSTR = (state_r == brk_pkg::ST_IDLE) && match_hit &&
	                      I_CPU.opcode_fetch;

	// Wait-exit flag: set when a break is taken out of wait mode
	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			wait_exit_r <= 1'b0;
		end else if (take_break && I_CPU.wait_mode) begin
			wait_exit_r <= 1'b1;
		end else if (wr_en && (PADDR == brk_pkg::OFS_WAIT_STAT) &&
		             !wbyte[brk_pkg::BIT_WAIT_EXIT]) begin
			wait_exit_r <= 1'b0;
		end else if (rti_end) begin
			wait_exit_r <= 1'b0;
		end
	end

	// ****************************************************************
	// System controls
	// ****************************************************************
	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_BREAK_ACTIVE       <= 1'b0;
			O_STATUS_CLEAR_ALLOW <= 1'b1;
			O_TIMER_FREEZE       <= 1'b0;
			O_WATCHDOG_DISABLE   <= 1'b0;
		end else begin
			O_BREAK_ACTIVE       <= (state_r == brk_pkg::ST_BREAK);
			O_STATUS_CLEAR_ALLOW <= (state_r != brk_pkg::ST_BREAK) || clr_en_r;
			O_TIMER_FREEZE       <= (state_r == brk_pkg::ST_BREAK);
			O_WATCHDOG_DISABLE   <= (state_r == brk_pkg::ST_BREAK) &&
			                        vtst_sync_r[1];
		end
	end

	// ****************************************************************
	// Interrupt status
	// ****************************************************************
	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			irq_stat_r <= brk_pkg::RST_IRQ;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if ((i == brk_pkg::IRQ_BREAK && take_break) ||
				    (i == brk_pkg::IRQ_MATCH && match_hit)) begin
					irq_stat_r[i] <= 1'b1;
				end else if (wr_en && (PADDR == brk_pkg::OFS_IRQ_STAT) && wbyte[i]) begin
					irq_stat_r[i] <= 1'b0;
				end
			end
		end
	end

	assign O_IRQ = |(irq_stat_r & irq_mask_r);

	// ****************************************************************
	// Read data
	// ****************************************************************
	logic [31:0] prdata_nxt;

	always_comb begin
		prdata_nxt = 32'h0000_0000;
		unique case (PADDR)
			brk_pkg::OFS_CTRL_STAT: prdata_nxt = {24'h0, enable_r, active_r, 6'h0};
			brk_pkg::OFS_ADDR_HIGH: prdata_nxt = {24'h0, addr_high_r};
			brk_pkg::OFS_ADDR_LOW:  prdata_nxt = {24'h0, addr_low_r};
			brk_pkg::OFS_WAIT_STAT: prdata_nxt = {30'h0, wait_exit_r, 1'b0};
			brk_pkg::OFS_FLAG_CLR:  prdata_nxt = {24'h0, clr_en_r, 7'h0};
			brk_pkg::OFS_IRQ_STAT:  prdata_nxt = {30'h0, irq_stat_r};
			brk_pkg::OFS_IRQ_MASK:  prdata_nxt = {30'h0, irq_mask_r};
			default:                prdata_nxt = 32'h0000_0000;
		endcase
	end

	// Loaded in the setup cycle so the word stands through the access phase
	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			PRDATA <= 32'h0000_0000;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			PRDATA <= prdata_nxt;
		end
	end

endmodule

/* File: sim/cpu_model.sv */
// Core-side model: drives one bus cycle per call, idles otherwise.
// Assumes the bench calls cyc away from clock edges.
`timescale 1ns/1ps
module cpu_model (
	// Clock
	input  wire logic            i_clk,
	// Core bus
	output brk_pkg::cpu_bus_type o_cpu
);
	logic [20:0] nxt = {16'h0100, 5'h00};
	initial o_cpu = '0;
	// Fall back to a fetch-free address so a match never lingers
	always @(posedge i_clk) begin
		o_cpu <= nxt;
		nxt <= {16'h0100, 5'h00};
	end
	task automatic cyc(input logic [15:0] a, input logic [4:0] f);
		#1;
		nxt = {a, f};
		@(posedge i_clk);
		#1;
	endtask
endmodule

/* File: sim/brk_unit_props.sv */
// Checker for the breakpoint unit: break entry, exit and system controls.
// Assumes it is bound to brk_unit and sees its ports only.
`timescale 1ns/1ps
module brk_unit_props #(
	parameter logic [7:0] SWI_OPCODE = brk_pkg::OPC_SWI_DFLT
) (
	// Clock, reset and bus
	input wire logic                 I_CORE_CLK,
	input wire logic                 I_RESET_N,
	input wire logic                 PSEL,
	input wire logic                 PENABLE,
	input wire logic [7:0]           PADDR,
	input wire logic                 PSLVERR,
	// Core side and pins
	input wire brk_pkg::cpu_bus_type I_CPU,
	input wire brk_pkg::brk_req_type O_BRK,
	input wire logic                 O_HOLD_INSTR,
	input wire logic                 I_MONITOR_MODE,
	input wire logic                 I_HIGH_TEST_VOLTAGE,
	// Controls
	input wire logic                 O_BREAK_ACTIVE,
	input wire logic                 O_TIMER_FREEZE,
	input wire logic                 O_WATCHDOG_DISABLE,
	input wire logic                 O_STATUS_CLEAR_ALLOW
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RESET_N);
	sequence s_enter;
		O_BRK.request ##1 O_BREAK_ACTIVE;
	endsequence
	property p_entry;
		O_HOLD_INSTR |=> s_enter;
	endproperty
	a_entry: assert property (p_entry) else $error("no break after held fetch");
	property p_pulse;
		O_BRK.request |=> !O_BRK.request;
	endproperty
	a_pulse: assert property (p_pulse) else $error("request longer than one cycle");
	property p_swi;
		O_BRK.request |-> O_BRK.inject_swi && O_BRK.swi_opcode == SWI_OPCODE &&
			O_BRK.vector == ($past(I_MONITOR_MODE, 3) ? brk_pkg::VEC_MONITOR : brk_pkg::VEC_NORMAL);
	endproperty
	a_swi: assert property (p_swi) else $error("bad opcode or vector");
	property p_freeze;
		O_TIMER_FREEZE == O_BREAK_ACTIVE;
	endproperty
	a_freeze: assert property (p_freeze) else $error("timer freeze wrong");
	property p_wdog;
		O_WATCHDOG_DISABLE |-> O_BREAK_ACTIVE;
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog off outside break");
	property p_wdog_tv;
		!I_HIGH_TEST_VOLTAGE [*4] |-> !O_WATCHDOG_DISABLE;
	endproperty
	a_wdog_tv: assert property (p_wdog_tv) else $error("watchdog off without voltage");
	property p_rti;
		O_BREAK_ACTIVE && I_CPU.rti_exec |-> ##2 !O_BREAK_ACTIVE;
	endproperty
	a_rti: assert property (p_rti) else $error("break not ended by return");
	property p_allow;
		!O_BREAK_ACTIVE |-> O_STATUS_CLEAR_ALLOW;
	endproperty
	a_allow: assert property (p_allow) else $error("clears blocked outside break");
	property p_quiet;
		I_CPU.wait_mode || I_CPU.stop_mode |-> !O_HOLD_INSTR;
	endproperty
	a_quiet: assert property (p_quiet) else $error("match in low-power mode");
	property p_unmapped;
		PSEL && PENABLE && PADDR > brk_pkg::OFS_IRQ_MASK |-> PSLVERR;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");
endmodule
bind brk_unit brk_unit_props #(.SWI_OPCODE(SWI_OPCODE)) props (.I_CORE_CLK, .I_RESET_N, .PSEL,
	.PENABLE, .PADDR, .PSLVERR, .I_CPU, .O_BRK, .O_HOLD_INSTR, .I_MONITOR_MODE,
	.I_HIGH_TEST_VOLTAGE, .O_BREAK_ACTIVE, .O_TIMER_FREEZE, .O_WATCHDOG_DISABLE,
	.O_STATUS_CLEAR_ALLOW);

/* File: sim/brk_unit_test.sv */
// Bench for the breakpoint unit: APB register traffic and core-side breaks.
// Assumes cpu_model on the core bus and the checker bound to the unit.
`timescale 1ns/1ps
module brk_unit_test;
	logic                 clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
	logic                 mon, tv, hold, act, allow, frz, wdog, irq;
	logic [7:0]           paddr;
	logic [31:0]          pwdata, prdata, rd;
	brk_pkg::cpu_bus_type cpu_bus;
	brk_pkg::brk_req_type brk;
	int                   err_total, checked, cycles;
	brk_unit dut (.I_CORE_CLK(clk), .I_RESET_N(rst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .I_CPU(cpu_bus), .O_BRK(brk),
		.O_HOLD_INSTR(hold), .I_MONITOR_MODE(mon), .I_HIGH_TEST_VOLTAGE(tv),
		.O_BREAK_ACTIVE(act), .O_STATUS_CLEAR_ALLOW(allow), .O_TIMER_FREEZE(frz),
		.O_WATCHDOG_DISABLE(wdog), .O_IRQ(irq));
	cpu_model cpu (.i_clk(clk), .o_cpu(cpu_bus));
	// ****************************************
	// Shared tasks
	// ****************************************
	task chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rdx(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task idle(input int n);
		repeat (n) cpu.cyc(16'h0100, 5'h00);
	endtask
	task endbrk;
		wr(brk_pkg::OFS_CTRL_STAT, 32'h80);
		cpu.cyc(16'h0100, 5'h04);
		idle(2);
		chk(act, 1'b0);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task t_regs;
		for (int a = 0; a < 28; a += 4)
			rdx(8'(a), 32'h0);
		rdx(8'h1c, 32'h0);
		chk(er, 1'b1);
		wr(brk_pkg::OFS_ADDR_HIGH, 32'h12);
		wr(brk_pkg::OFS_ADDR_LOW, 32'h34);
		rdx(brk_pkg::OFS_ADDR_HIGH, 32'h12);
		rdx(brk_pkg::OFS_ADDR_LOW, 32'h34);
		wr(brk_pkg::OFS_CTRL_STAT, 32'h80);
		rdx(brk_pkg::OFS_CTRL_STAT, 32'h80);
		wr(brk_pkg::OFS_IRQ_MASK, 32'h3);
	endtask
	task t_match;
		cpu.cyc(16'h1234, 5'h10);
		chk(hold, 1'b1);
		cpu.cyc(16'h1235, 5'h00);
		chk({brk.request, brk.swi_opcode, brk.vector}, {9'h183, brk_pkg::VEC_NORMAL});
		idle(1);
		chk({act, frz, wdog, allow}, 4'hc);
		rdx(brk_pkg::OFS_CTRL_STAT, 32'hc0);
		chk(irq, 1'b1);
		wr(brk_pkg::OFS_IRQ_STAT, 32'h3);
		idle(1);
		chk(irq, 1'b0);
		wr(brk_pkg::OFS_FLAG_CLR, 32'h80);
		idle(2);
		chk(allow, 1'b1);
		wr(brk_pkg::OFS_FLAG_CLR, 32'h0);
		@(posedge clk) tv <= 1'b1;
		idle(5);
		chk({allow, wdog}, 2'h1);
		@(posedge clk) tv <= 1'b0;
		endbrk;
		rdx(brk_pkg::OFS_WAIT_STAT, 32'h0);
		cpu.cyc(16'h1234, 5'h10);
		chk(hold, 1'b0);
	endtask
	task t_soft;
		@(posedge clk) mon <= 1'b1;
		wr(brk_pkg::OFS_IRQ_MASK, 32'h0);
		wr(brk_pkg::OFS_CTRL_STAT, 32'hc0);
		idle(3);
		chk(brk.request, 1'b0);
		cpu.cyc(16'h0100, 5'h0a);
		idle(1);
		chk({brk.request, brk.vector}, {1'b1, brk_pkg::VEC_MONITOR});
		rdx(brk_pkg::OFS_WAIT_STAT, 32'h2);
		idle(1);
		chk(irq, 1'b0);
		wr(brk_pkg::OFS_IRQ_MASK, 32'h1);
		idle(1);
		chk(irq, 1'b1);
		wr(brk_pkg::OFS_IRQ_STAT, 32'h3);
		endbrk;
		@(posedge clk) mon <= 1'b0;
	endtask
	task t_operand;
		wr(brk_pkg::OFS_ADDR_LOW, 32'h34);
		cpu.cyc(16'h1234, 5'h00);
		chk(hold, 1'b0);
		idle(1);
		chk(brk.request, 1'b0);
		cpu.cyc(16'h0100, 5'h08);
		idle(1);
		chk(brk.request, 1'b1);
		endbrk;
	endtask
	task t_gate;
		wr(brk_pkg::OFS_ADDR_LOW, 32'h34);
		wr(brk_pkg::OFS_CTRL_STAT, 32'h0);
		cpu.cyc(16'h1234, 5'h10);
		chk(hold, 1'b0);
		wr(brk_pkg::OFS_CTRL_STAT, 32'h80);
		cpu.cyc(16'h1334, 5'h10);
		chk(hold, 1'b0);
		cpu.cyc(16'h1234, 5'h12);
		chk(hold, 1'b0);
		cpu.cyc(16'h1234, 5'h11);
		chk(hold, 1'b0);
		idle(3);
		chk(act, 1'b0);
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			results;
		end
	end
	initial begin
		{rst_n, psel, penable, pwrite, mon, tv} = 6'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_regs;
		t_match;
		t_soft;
		t_operand;
		t_gate;
		results;
	end
endmodule
